// ### design/dcpr_defines.vh
// Offsets, field positions and reset values for the channel priority bank.
// Assumes inclusion by bare name from every design file of the bank.
`ifndef DCPR_DEFINES_VH
`define DCPR_DEFINES_VH

`define DCPR_NUM_CHAN        32
`define DCPR_ID_W            5
`define DCPR_ADDR_W          8
`define DCPR_DATA_W          32
`define DCPR_EVT_W           2

`define DCPR_OFS_PRIO_SET    8'h00
`define DCPR_OFS_PRIO_CLEAR  8'h04
`define DCPR_OFS_ERR_CLEAR   8'h08
`define DCPR_OFS_IRQ_STATUS  8'h0C
`define DCPR_OFS_IRQ_ENABLE  8'h10
`define DCPR_OFS_IRQ_CLEAR   8'h14
`define DCPR_OFS_REQ_VIEW    8'h18
`define DCPR_OFS_GRANT_VIEW  8'h1C
`define DCPR_OFS_ARB_CTRL    8'h20

`define DCPR_ERR_BIT         0
`define DCPR_EVT_BUS_ERR     0
`define DCPR_EVT_BAD_ADDR    1
`define DCPR_ARB_EN_BIT      0
`define DCPR_GRANT_VALID_BIT 5

`define DCPR_RST_PRIO        32'h00000000
`define DCPR_RST_ERR         1'b0
`define DCPR_RST_EVT         2'h0
`define DCPR_RST_ARB_CTRL    1'b0
`define DCPR_RST_DATA        32'h00000000

`endif

// ### design/dcpr_irq.v
// Sticky event status with enable mask and write-one-to-clear.
// Assumes events and strobes come from logic on CLK_SYS.
`include "dcpr_defines.vh"

module dcpr_irq (
   input  wire                   clk,
   input  wire                   nrst,
   input  wire [`DCPR_EVT_W-1:0] event_in,
   input  wire                   enable_wr,
   input  wire                   clear_wr,
   input  wire [`DCPR_EVT_W-1:0] wdata,
   output reg  [`DCPR_EVT_W-1:0] status,
   output reg  [`DCPR_EVT_W-1:0] enable,
   output wire                   irq
);

   wire [`DCPR_EVT_W-1:0] clear_mask;
   wire [`DCPR_EVT_W-1:0] next_status;

   assign clear_mask  = clear_wr ? wdata : `DCPR_RST_EVT;
   // Set wins so an event in the clearing cycle survives
   assign next_status = (status & ~clear_mask) | event_in;
   assign irq         = |(status & enable);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status <= `DCPR_RST_EVT;
         enable <= `DCPR_RST_EVT;
      end else begin
         status <= next_status;
         if (enable_wr) begin
            enable <= wdata;
         end
      end
   end

endmodule

// ### design/dcpr_arbiter.v
// Picks one requesting channel per cycle, high priority before normal.
// Assumes requests and priority come from logic on CLK_SYS.
`include "dcpr_defines.vh"

module dcpr_arbiter (
   input  wire                      clk,
   input  wire                      nrst,
   input  wire                      arb_en,
   input  wire [`DCPR_NUM_CHAN-1:0] req,
   input  wire [`DCPR_NUM_CHAN-1:0] high,
   output reg  [`DCPR_NUM_CHAN-1:0] grant,
   output reg  [`DCPR_ID_W-1:0]     grant_id,
   output reg                       grant_valid
);

   wire [`DCPR_NUM_CHAN-1:0] high_req;
   wire [`DCPR_NUM_CHAN-1:0] pool;
   wire [`DCPR_NUM_CHAN-1:0] pick;
   wire [`DCPR_NUM_CHAN-1:0] below;
   wire [`DCPR_ID_W-1:0]     id_part [0:`DCPR_NUM_CHAN-1];

   assign high_req = req & high;
   // Normal channels only compete when no high one asks
   assign pool = (|high_req) ? high_req : req;

   genvar i;
   generate
      for (i = 0; i < `DCPR_NUM_CHAN; i = i + 1) begin : g_chan
         if (i == 0) begin : g_first
            assign below[i] = 1'b0;
         end else begin : g_rest
            assign below[i] = below[i-1] | pool[i-1];
         end
         // Lowest index wins inside the chosen class
         assign pick[i] = pool[i] & ~below[i];
         // Ranged copy of the loop index so its low bits can be selected
         localparam [31:0] CHAN_NUM = i;
         if (i == 0) begin : g_id0
            assign id_part[i] = pick[i] ? CHAN_NUM[`DCPR_ID_W-1:0] : 5'h00;
         end else begin : g_idn
            assign id_part[i] = id_part[i-1] | (pick[i] ? CHAN_NUM[`DCPR_ID_W-1:0] : 5'h00);
         end
      end
   endgenerate

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         grant       <= `DCPR_RST_PRIO;
         grant_id    <= 5'h00;
         grant_valid <= 1'b0;
      end else if (arb_en) begin
         grant       <= pick;
         grant_id    <= id_part[`DCPR_NUM_CHAN-1];
         grant_valid <= |pool;
      end else begin
         grant       <= `DCPR_RST_PRIO;
         grant_id    <= 5'h00;
         grant_valid <= 1'b0;
      end
   end

endmodule

// ### design/dcpr_regs.v
// Channel priority register bank of a 32-channel DMA controller on APB.
// Assumes the DMA engine drives requests and bus errors on CLK_SYS.
`include "dcpr_defines.vh"

module dcpr_regs (
   input  wire                      CLK_SYS,
   input  wire                      NRST,
   input  wire                      PSEL,
   input  wire                      PENABLE,
   input  wire                      PWRITE,
   input  wire [`DCPR_ADDR_W-1:0]   PADDR,
   input  wire [`DCPR_DATA_W-1:0]   PWDATA,
   output reg  [`DCPR_DATA_W-1:0]   PRDATA,
   output wire                      PREADY,
   output wire                      PSLVERR,
   input  wire                      BUS_ERROR,
   input  wire [`DCPR_NUM_CHAN-1:0] CHAN_REQ,
   output wire [`DCPR_NUM_CHAN-1:0] HIGH_PRIORITY,
   output wire [`DCPR_NUM_CHAN-1:0] CHAN_GRANT,
   output wire [`DCPR_ID_W-1:0]     GRANT_ID,
   output wire                      GRANT_VALID,
   output wire                      IRQ
);

   reg  [`DCPR_NUM_CHAN-1:0] prio;
   reg                       err_pending;
   reg                       arb_en;
   reg  [`DCPR_DATA_W-1:0]   next_rdata;

   wire                      setup_rd;
   wire                      access;
   wire                      wr;
   wire                      sel_set;
   wire                      sel_clear;
   wire                      sel_err;
   wire                      sel_status;
   wire                      sel_enable;
   wire                      sel_irq_clr;
   wire                      sel_req;
   wire                      sel_grant;
   wire                      sel_ctrl;
   wire                      mapped;
   wire                      bad_access;
   wire [`DCPR_NUM_CHAN-1:0] set_mask;
   wire [`DCPR_NUM_CHAN-1:0] clr_mask;
   wire [`DCPR_NUM_CHAN-1:0] next_prio;
   wire                      err_clear;
   wire                      next_err;
   wire [`DCPR_EVT_W-1:0]    events;
   wire [`DCPR_EVT_W-1:0]    irq_status;
   wire [`DCPR_EVT_W-1:0]    irq_enable;

   // Zero wait states: every access completes in its first access cycle
   assign PREADY  = 1'b1;
   assign access  = PSEL & PENABLE;
   assign wr      = access & PWRITE;
   // Read data is captured in setup so it comes from a flop in access
   assign setup_rd = PSEL & ~PENABLE & ~PWRITE;

   assign sel_set     = (PADDR == `DCPR_OFS_PRIO_SET);
   assign sel_clear   = (PADDR == `DCPR_OFS_PRIO_CLEAR);
   assign sel_err     = (PADDR == `DCPR_OFS_ERR_CLEAR);
   assign sel_status  = (PADDR == `DCPR_OFS_IRQ_STATUS);
   assign sel_enable  = (PADDR == `DCPR_OFS_IRQ_ENABLE);
   assign sel_irq_clr = (PADDR == `DCPR_OFS_IRQ_CLEAR);
   assign sel_req     = (PADDR == `DCPR_OFS_REQ_VIEW);
   assign sel_grant   = (PADDR == `DCPR_OFS_GRANT_VIEW);
   assign sel_ctrl    = (PADDR == `DCPR_OFS_ARB_CTRL);

   assign mapped = sel_set | sel_clear | sel_err | sel_status | sel_enable |
                   sel_irq_clr | sel_req | sel_grant | sel_ctrl;
   // Unaligned or unknown addresses answer with an error and only raise the bad address event
   assign bad_access = access & ~mapped;
   assign PSLVERR    = bad_access;

   // Only the one bits of the written word act on a channel
   assign set_mask  = (wr & sel_set)   ? PWDATA : `DCPR_RST_PRIO;
   assign clr_mask  = (wr & sel_clear) ? PWDATA : `DCPR_RST_PRIO;
   // Bit n of each mask acts on channel n alone
   assign next_prio = (prio & ~clr_mask) | set_mask;

   assign err_clear = wr & sel_err & PWDATA[`DCPR_ERR_BIT];
   // A new bus error in the clearing cycle stays pending
   assign next_err  = BUS_ERROR | (err_pending & ~err_clear);

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         prio        <= `DCPR_RST_PRIO;
         err_pending <= `DCPR_RST_ERR;
         arb_en      <= `DCPR_RST_ARB_CTRL;
      end else begin
         prio        <= next_prio;
         err_pending <= next_err;
         if (wr & sel_ctrl) begin
            arb_en <= PWDATA[`DCPR_ARB_EN_BIT];
         end
      end
   end

   always @* begin
      next_rdata = `DCPR_RST_DATA;
      if (sel_set) begin
         next_rdata = prio;
      end else if (sel_clear) begin
         next_rdata = `DCPR_RST_DATA;
      end else if (sel_err) begin
         next_rdata[`DCPR_ERR_BIT] = err_pending;
      end else if (sel_status) begin
         next_rdata[`DCPR_EVT_W-1:0] = irq_status;
      end else if (sel_enable) begin
         next_rdata[`DCPR_EVT_W-1:0] = irq_enable;
      end else if (sel_req) begin
         next_rdata = CHAN_REQ;
      end else if (sel_grant) begin
         next_rdata[`DCPR_ID_W-1:0]           = GRANT_ID;
         next_rdata[`DCPR_GRANT_VALID_BIT]    = GRANT_VALID;
      end else if (sel_ctrl) begin
         next_rdata[`DCPR_ARB_EN_BIT] = arb_en;
      end
   end

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= `DCPR_RST_DATA;
      end else if (setup_rd) begin
         PRDATA <= next_rdata;
      end
   end

   assign HIGH_PRIORITY = prio;

   assign events[`DCPR_EVT_BUS_ERR]  = BUS_ERROR;
   assign events[`DCPR_EVT_BAD_ADDR] = bad_access;

   dcpr_irq u_irq (
      .clk       (CLK_SYS),
      .nrst      (NRST),
      .event_in  (events),
      .enable_wr (wr & sel_enable),
      .clear_wr  (wr & sel_irq_clr),
      .wdata     (PWDATA[`DCPR_EVT_W-1:0]),
      .status    (irq_status),
      .enable    (irq_enable),
      .irq       (IRQ)
   );

   dcpr_arbiter u_arb (
      .clk         (CLK_SYS),
      .nrst        (NRST),
      .arb_en      (arb_en),
      .req         (CHAN_REQ),
      .high        (prio),
      .grant       (CHAN_GRANT),
      .grant_id    (GRANT_ID),
      .grant_valid (GRANT_VALID)
   );

endmodule

// ### tb/dcpr_regs_assertions.sv
// Concurrent checks on the channel priority bank ports.
// Assumes a bind onto dcpr_regs; only its ports are seen.
module dcpr_regs_chk (
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [31:0] CHAN_REQ,
   input wire logic [31:0] HIGH_PRIORITY,
   input wire logic [31:0] CHAN_GRANT,
   input wire logic [4:0]  GRANT_ID,
   input wire logic        GRANT_VALID
);
   logic [31:0] pr;
   logic [31:0] ph;
   logic        wr;
   logic        rd;
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && PENABLE && !PWRITE;
   // Grant reflects the previous cycle, so keep that cycle's inputs
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pr <= '0;
         ph <= '0;
      end else begin
         pr <= CHAN_REQ;
         ph <= HIGH_PRIORITY;
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   set_write_a:
      assert property (wr && PADDR == 8'h00 |=> HIGH_PRIORITY == ($past(HIGH_PRIORITY) | $past(PWDATA)))
      else $error("priority set write wrong");
   clear_write_a:
      assert property (wr && PADDR == 8'h04 |=> HIGH_PRIORITY == ($past(HIGH_PRIORITY) & ~$past(PWDATA)))
      else $error("priority clear write wrong");
   prio_hold_a:
      assert property (!(wr && (PADDR == 8'h00 || PADDR == 8'h04)) |=> $stable(HIGH_PRIORITY))
      else $error("priority changed without write");
   set_read_a:
      assert property (rd && PADDR == 8'h00 |-> PRDATA == HIGH_PRIORITY)
      else $error("priority read wrong");
   clear_read_a:
      assert property (rd && PADDR == 8'h04 |-> PRDATA == 32'h00000000)
      else $error("clear register read not zero");
   err_read_a:
      assert property (rd && PADDR == 8'h08 |-> PRDATA[31:1] == 31'h0)
      else $error("error register upper bits set");
   grant_pick_a:
      assert property (GRANT_VALID |-> pr[GRANT_ID] && (ph[GRANT_ID] || !(|(pr & ph))) && CHAN_GRANT == (32'h1 << GRANT_ID))
      else $error("grant not to a high priority requester");
   ready_now_a: // [APB]
      assert property (PSEL && !PENABLE |=> PREADY)
      else $error("access phase not ready");
   bad_addr_a: // [APB]
      assert property (PSEL && PENABLE && (PADDR > 8'h20 || PADDR[1:0] != 2'h0) |-> PSLVERR)
      else $error("unmapped access not refused");
endmodule

bind dcpr_regs dcpr_regs_chk i_dcpr_regs_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CHAN_REQ(CHAN_REQ), .HIGH_PRIORITY(HIGH_PRIORITY), .CHAN_GRANT(CHAN_GRANT), .GRANT_ID(GRANT_ID),
   .GRANT_VALID(GRANT_VALID));

// ### tb/testbench.sv
// Self-checking bench for the channel priority bank over APB.
// Assumes dcpr_regs with zero wait states; no other model needed.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, bus_error = 0, irq, pready, pslverr, gv;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, chan_req = 32'h0, prdata, hp, cg, rv;
   logic [4:0] gid;
   logic err_seen;
   int err_total = 0, comparisons = 0;
   dcpr_regs i_dcpr_regs (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BUS_ERROR(bus_error), .CHAN_REQ(chan_req), .HIGH_PRIORITY(hp), .CHAN_GRANT(cg), .GRANT_ID(gid),
      .GRANT_VALID(gv), .IRQ(irq));
   always #50 clk = ~clk;
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rv = prdata;
      err_seen = pslverr;
      psel <= 0;
      penable <= 0;
      // Let the answering edge settle before anyone looks at outputs
      @(negedge clk);
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task t_prio;
      acc(0, 8'h00, 0); chk("prio reset", 32'h0, rv);
      acc(1, 8'h00, 32'h80000001); acc(0, 8'h00, 0); chk("set ends", 32'h80000001, rv);
      acc(1, 8'h00, 32'h00000100); acc(0, 8'h00, 0); chk("set keeps", 32'h80000101, rv);
      acc(1, 8'h04, 32'h80000000); acc(0, 8'h00, 0); chk("clear", 32'h00000101, rv);
      acc(1, 8'h04, 32'h0); acc(0, 8'h00, 0); chk("clear zero", 32'h00000101, rv);
      chk("prio port", 32'h00000101, hp);
      acc(0, 8'h04, 0); chk("clear read", 32'h0, rv);
      $display("test prio done");
   endtask
   task t_err;
      @(posedge clk) bus_error <= 1;
      @(posedge clk) bus_error <= 0;
      acc(0, 8'h08, 0); chk("err pending", 32'h1, rv);
      acc(1, 8'h08, 0); acc(0, 8'h08, 0); chk("err write0", 32'h1, rv);
      acc(1, 8'h08, 1); acc(0, 8'h08, 0); chk("err cleared", 32'h0, rv);
      acc(0, 8'h0C, 0); chk("irq bus err", 32'h1, rv);
      acc(1, 8'h14, 3);
      $display("test err done");
   endtask
   task t_irq;
      acc(1, 8'h10, 2);
      acc(0, 8'h24, 0); chk("slverr", 32'h1, {31'h0, err_seen}); chk("bad read", 32'h0, rv);
      chk("irq on", 32'h1, {31'h0, irq});
      acc(0, 8'h0C, 0); chk("status", 32'h2, rv);
      acc(1, 8'h10, 0); chk("irq masked", 32'h0, {31'h0, irq});
      acc(1, 8'h10, 2); acc(1, 8'h14, 2); acc(0, 8'h0C, 0); chk("cleared", 32'h0, rv);
      chk("irq off", 32'h0, {31'h0, irq});
      $display("test irq done");
   endtask
   task t_arb;
      acc(1, 8'h20, 1); acc(1, 8'h04, 32'hFFFFFFFF); acc(1, 8'h00, 32'h00000200);
      @(posedge clk) chan_req <= 32'h00000208;
      repeat (2) @(negedge clk);
      chk("grant high", 32'h29, {26'h0, gv, gid});
      acc(1, 8'h04, 32'h00000200);
      repeat (2) @(negedge clk);
      chk("grant normal", 32'h23, {26'h0, gv, gid}); chk("grant vec", 32'h8, cg);
      acc(0, 8'h18, 0); chk("req view", 32'h208, rv);
      acc(0, 8'h1C, 0); chk("grant view", 32'h23, rv);
      acc(0, 8'h20, 0); chk("arb ctrl", 32'h1, rv);
      acc(1, 8'h20, 0);
      repeat (2) @(negedge clk);
      chk("arb off", 32'h0, {26'h0, gv, gid}); chk("arb off vec", 32'h0, cg);
      $display("test arb done");
   endtask
   task t_reset;
      acc(1, 8'h00, 32'h0000F00F);
      @(posedge clk) nrst <= 0;
      @(posedge clk) nrst <= 1;
      @(negedge clk) chk("reset hp", 32'h0, hp);
      acc(0, 8'h00, 0); chk("reset read", 32'h0, rv);
      $display("test reset done");
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      test_done;
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1;
      t_prio;
      t_err;
      t_irq;
      t_arb;
      t_reset;
      test_done;
   end
endmodule
